// file: common/pirq_params.svh
`ifndef PIRQ_PARAMS_SVH
`define PIRQ_PARAMS_SVH

// Register byte offsets
`define PIRQ_OFF_ENABLE 12'h000
`define PIRQ_OFF_REQUEST 12'h004
`define PIRQ_OFF_CTRL 12'h008
`define PIRQ_OFF_STATUS 12'h00C
`define PIRQ_OFF_CLEAR 12'h010
`define PIRQ_OFF_IRQEN 12'h014

// Field positions
`define PIRQ_BIT_EEWR 7
`define PIRQ_BIT_LVD 6
`define PIRQ_BIT_CRYPTO 5
`define PIRQ_BIT_CMPB 4
`define PIRQ_BIT_CMPA 3
`define PIRQ_BIT_OSCF 2
`define PIRQ_BIT_UNUSED 1
`define PIRQ_BIT_TMR1 0
`define PIRQ_BIT_GLOBAL_EN 1
`define PIRQ_BIT_PERIPH_EN 0

// Reset values and masks
`define PIRQ_RST_BYTE 8'h00
`define PIRQ_IMPL_MASK 8'hFD
`define PIRQ_CTRL_MASK 8'h03
`define PIRQ_EVT_MASK 8'h01

// Timing counts
`define PIRQ_ARM_CYCLES 3'h5

`endif

// file: common/pirq_pkg.sv
package pirq_pkg;

    typedef enum logic [1:0] {
        PIRQ_IDLE = 2'b00,
        PIRQ_ACCESS = 2'b01
    } pirq_bus_t;

    typedef struct packed {
        pirq_bus_t busState;
        logic [7:0] enableReg;
        logic [7:0] requestReg;
        logic [1:0] ctrlReg;
        logic evtStatusReg;
        logic evtEnableReg;
        logic [31:0] prdataReg;
        logic preadyReg;
        logic pslverrReg;
        logic coreIrqReg;
        logic busIrqReg;
        logic [7:0] pendingReg;
    } pirq_state_t;

endpackage : pirq_pkg

// file: src/pirq_event_sync.sv
`timescale 1ns/1ps
`include "pirq_params.svh"

// Three-stage synchroniser; change accepted when stages two and three agree
module pirq_event_sync #(
    parameter int WIDTH = 7
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic clkEn,
    // Asynchronous inputs and synchronised levels
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);

    logic [WIDTH-1:0] stageOne_reg;
    logic [WIDTH-1:0] stageTwo_reg;
    logic [WIDTH-1:0] stageThree_reg;
    logic [WIDTH-1:0] syncOut_reg;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : gBit
            always_ff @(posedge clk_sys or negedge rstn) begin
                if (!rstn) begin
                    stageOne_reg[i] <= 1'b0;
                    stageTwo_reg[i] <= 1'b0;
                    stageThree_reg[i] <= 1'b0;
                    syncOut_reg[i] <= 1'b0;
                end else if (clkEn) begin
                    stageOne_reg[i] <= asyncIn[i];
                    stageTwo_reg[i] <= stageOne_reg[i];
                    stageThree_reg[i] <= stageTwo_reg[i];
                    if (stageTwo_reg[i] == stageThree_reg[i]) begin
                        syncOut_reg[i] <= stageThree_reg[i];
                    end
                end
            end
        end
    endgenerate

    assign syncOut = syncOut_reg;

endmodule : pirq_event_sync

// file: src/pirq_flag_bank.sv
// Design decisions made here: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`include "pirq_params.svh"

// Overview of operation
// - No core request without peripheral enable
// - Enable register holds one mask per source
// - Bit one unimplemented, reads zero
// - Flags set regardless of any interrupt enable bit
// - EE write done sets bit seven
// - Low-voltage crossing sets bit six
// - Crypto completion sets bit five
// - Comparator B output change sets bit four
// - Comparator A output change sets bit three
// - Oscillator failure sets bit two
// - Timer1 rollover sets bit zero
// - Global enable gates every source
module pirq_flag_bank #(
    parameter bit HAS_CMP_B = 1'b1
) (
    // Clock, enable and reset
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic clkEn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Peripheral event pulses, same clock
    input wire logic eewriteDone,
    input wire logic cryptoDone,
    input wire logic timerOneOvf,
    // Asynchronous peripheral levels
    input wire logic lowvoltCrossed,
    input wire logic cmpBOutput,
    input wire logic cmpAOutput,
    input wire logic oscFailed,
    // Interrupt outputs
    output logic coreIrq,
    output logic busIrq
);

    pirq_pkg::pirq_state_t st_reg;
    pirq_pkg::pirq_state_t st_next;

    logic [3:0] syncLevel;
    logic [3:0] syncPrev_reg;
    logic [2:0] armCnt_reg;
    logic armed;
    logic [7:0] eventVec;
    logic setupPhase;
    logic accessDone;
    logic wrStrobe;
    logic [7:0] wrByte;

    // ------------------------------------------------------------
    // Input synchronisation and edge detection
    // ------------------------------------------------------------
    pirq_event_sync #(
        .WIDTH(4)
    ) uSync (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .clkEn(clkEn),
        .asyncIn({lowvoltCrossed, cmpBOutput, cmpAOutput, oscFailed}),
        .syncOut(syncLevel)
    );

    // Count edges after reset until the synchroniser holds pin levels
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            syncPrev_reg <= 4'h0;
            armCnt_reg <= 3'h0;
        end else if (clkEn) begin
            syncPrev_reg <= syncLevel;
            if (!armed) begin
                armCnt_reg <= 3'(armCnt_reg + 3'h1);
            end
        end
    end

    assign armed = (armCnt_reg == `PIRQ_ARM_CYCLES);

    always_comb begin
        eventVec = 8'h00;
        eventVec[`PIRQ_BIT_EEWR] = eewriteDone;
        eventVec[`PIRQ_BIT_LVD] = syncLevel[3] & ~syncPrev_reg[3];
        eventVec[`PIRQ_BIT_CRYPTO] = cryptoDone;
        eventVec[`PIRQ_BIT_CMPB] = HAS_CMP_B &
            (syncLevel[2] ^ syncPrev_reg[2]);
        eventVec[`PIRQ_BIT_CMPA] = syncLevel[1] ^ syncPrev_reg[1];
        eventVec[`PIRQ_BIT_OSCF] = syncLevel[0] & ~syncPrev_reg[0];
        eventVec[`PIRQ_BIT_TMR1] = timerOneOvf;
        // Drop the false edges seen while the synchroniser fills
        if (!armed) begin
            eventVec[`PIRQ_BIT_LVD] = 1'b0;
            eventVec[`PIRQ_BIT_CMPB] = 1'b0;
            eventVec[`PIRQ_BIT_CMPA] = 1'b0;
            eventVec[`PIRQ_BIT_OSCF] = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    assign setupPhase = psel & ~penable;
    assign accessDone = psel & penable & st_reg.preadyReg;
    assign wrStrobe = accessDone & pwrite;
    assign wrByte = pwdata[7:0];

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic [7:0] reqNext;
        logic [7:0] enNext;
        logic [7:0] pendNext;
        logic hit;
        reqNext = st_reg.requestReg;
        enNext = st_reg.enableReg;
        pendNext = 8'h00;
        hit = 1'b0;
        st_next = st_reg;
        st_next.preadyReg = 1'b0;
        st_next.pslverrReg = 1'b0;

        if (wrStrobe) begin
            case (paddr)
                `PIRQ_OFF_ENABLE: begin
                    enNext = wrByte & `PIRQ_IMPL_MASK;
                end
                `PIRQ_OFF_REQUEST: begin
                    reqNext = wrByte & `PIRQ_IMPL_MASK;
                end
                `PIRQ_OFF_CTRL: begin
                    st_next.ctrlReg = wrByte[1:0];
                end
                `PIRQ_OFF_CLEAR: begin
                    if (wrByte[0]) begin
                        st_next.evtStatusReg = 1'b0;
                    end
                end
                `PIRQ_OFF_IRQEN: begin
                    st_next.evtEnableReg = wrByte[0];
                end
                default: begin
                    st_next.evtStatusReg = st_reg.evtStatusReg;
                end
            endcase
        end

        // Hardware set wins over a software clear in the same cycle
        reqNext = (reqNext | eventVec) & `PIRQ_IMPL_MASK;
        st_next.requestReg = reqNext;
        st_next.enableReg = enNext;

        pendNext = reqNext & enNext;
        st_next.pendingReg = pendNext;
        st_next.coreIrqReg = (|pendNext) &
            st_next.ctrlReg[`PIRQ_BIT_PERIPH_EN] &
            st_next.ctrlReg[`PIRQ_BIT_GLOBAL_EN];

        if (st_next.coreIrqReg & ~st_reg.coreIrqReg) begin
            st_next.evtStatusReg = 1'b1;
        end
        st_next.busIrqReg = st_next.evtStatusReg & st_next.evtEnableReg;

        case (st_reg.busState)
            pirq_pkg::PIRQ_IDLE: begin
                if (setupPhase) begin
                    st_next.busState = pirq_pkg::PIRQ_ACCESS;
                    st_next.preadyReg = 1'b1;
                    hit = 1'b1;
                    st_next.prdataReg = 32'h0000_0000;
                    case (paddr)
                        `PIRQ_OFF_ENABLE: begin
                            st_next.prdataReg[7:0] = st_reg.enableReg;
                        end
                        `PIRQ_OFF_REQUEST: begin
                            st_next.prdataReg[7:0] = st_reg.requestReg;
                        end
                        `PIRQ_OFF_CTRL: begin
                            st_next.prdataReg[1:0] = st_reg.ctrlReg;
                        end
                        `PIRQ_OFF_STATUS: begin
                            st_next.prdataReg[0] = st_reg.evtStatusReg;
                        end
                        `PIRQ_OFF_CLEAR: begin
                            st_next.prdataReg[0] = 1'b0;
                        end
                        `PIRQ_OFF_IRQEN: begin
                            st_next.prdataReg[0] = st_reg.evtEnableReg;
                        end
                        default: begin
                            hit = 1'b0;
                        end
                    endcase
                    st_next.pslverrReg = ~hit;
                end
            end
            pirq_pkg::PIRQ_ACCESS: begin
                st_next.busState = pirq_pkg::PIRQ_IDLE;
            end
            default: begin
                st_next.busState = pirq_pkg::PIRQ_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            st_reg <= '0;
        end else if (clkEn) begin
            st_reg <= st_next;
        end
    end

    assign prdata = st_reg.prdataReg;
    assign pready = st_reg.preadyReg;
    assign pslverr = st_reg.pslverrReg;
    assign coreIrq = st_reg.coreIrqReg;
    assign busIrq = st_reg.busIrqReg;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);

    sequence evtSeen_s(int b);
        clkEn && eventVec[b];
    endsequence

    sequence apbSetup_s;
        clkEn && setupPhase && st_reg.busState == pirq_pkg::PIRQ_IDLE;
    endsequence

    unused_bits_a: assert property (
        st_reg.requestReg[1] == 1'b0 && st_reg.enableReg[1] == 1'b0)
        else $error("unimplemented bit set");

    periph_gate_a: assert property (
        !st_reg.ctrlReg[`PIRQ_BIT_PERIPH_EN] |-> !coreIrq)
        else $error("irq without peripheral enable");

    global_gate_a: assert property (
        !st_reg.ctrlReg[`PIRQ_BIT_GLOBAL_EN] |-> !coreIrq)
        else $error("irq without global enable");

    irq_combine_a: assert property (
        coreIrq == ((|(st_reg.requestReg & st_reg.enableReg)) &
        st_reg.ctrlReg[`PIRQ_BIT_PERIPH_EN] &
        st_reg.ctrlReg[`PIRQ_BIT_GLOBAL_EN]))
        else $error("core irq mismatch");

    flag_set_a: assert property (
        evtSeen_s(`PIRQ_BIT_EEWR) |=> st_reg.requestReg[7])
        else $error("ee flag not set");

    lvd_set_a: assert property (
        evtSeen_s(`PIRQ_BIT_LVD) |=> st_reg.requestReg[6])
        else $error("lowvolt flag not set");

    crypto_set_a: assert property (
        evtSeen_s(`PIRQ_BIT_CRYPTO) |=> st_reg.requestReg[5])
        else $error("crypto flag not set");

    cmpb_set_a: assert property (
        evtSeen_s(`PIRQ_BIT_CMPB) |=> st_reg.requestReg[4])
        else $error("cmp b flag not set");

    cmpa_set_a: assert property (
        evtSeen_s(`PIRQ_BIT_CMPA) |=> st_reg.requestReg[3])
        else $error("cmp a flag not set");

    osc_set_a: assert property (
        evtSeen_s(`PIRQ_BIT_OSCF) |=> st_reg.requestReg[2])
        else $error("osc flag not set");

    timer_set_a: assert property (
        evtSeen_s(`PIRQ_BIT_TMR1) |=> st_reg.requestReg[0])
        else $error("timer flag not set");

    flag_sticky_a: assert property (
        (clkEn && !wrStrobe && st_reg.requestReg[3])
        |=> st_reg.requestReg[3])
        else $error("comparator flag lost");

    lvd_sticky_a: assert property (
        (clkEn && !wrStrobe && st_reg.requestReg[6])
        |=> st_reg.requestReg[6])
        else $error("lowvolt flag lost");

    osc_sticky_a: assert property (
        (clkEn && !wrStrobe && st_reg.requestReg[2])
        |=> st_reg.requestReg[2])
        else $error("osc flag lost");

    cmpb_sticky_a: assert property (
        (clkEn && !wrStrobe && st_reg.requestReg[4])
        |=> st_reg.requestReg[4])
        else $error("cmp b flag lost");

    enable_write_a: assert property (
        (clkEn && wrStrobe && paddr == `PIRQ_OFF_ENABLE)
        |=> st_reg.enableReg == ($past(pwdata[7:0]) & `PIRQ_IMPL_MASK))
        else $error("enable write wrong");

    read_enable_a: assert property (
        apbSetup_s ##0 (!pwrite && paddr == `PIRQ_OFF_ENABLE)
        |=> prdata == {24'h000000, $past(st_reg.enableReg)})
        else $error("enable read wrong");

    ready_answer_a: assert property (
        apbSetup_s |=> pready)
        else $error("no ready after setup");

    ready_pulse_a: assert property (
        (clkEn && pready) |=> !pready)
        else $error("ready held too long");

    unmapped_err_a: assert property (
        apbSetup_s ##0 (paddr > `PIRQ_OFF_IRQEN) |=> pslverr)
        else $error("no error on unmapped address");

    status_set_a: assert property (
        $rose(coreIrq) |-> st_reg.evtStatusReg)
        else $error("status not set on irq");

    bus_irq_a: assert property (
        busIrq == (st_reg.evtStatusReg & st_reg.evtEnableReg))
        else $error("bus irq mismatch");

    freeze_hold_a: assert property (
        !clkEn |=> $stable(st_reg))
        else $error("state moved while frozen");

    arm_mask_a: assert property (
        !armed |-> (eventVec & 8'h5C) == 8'h00)
        else $error("pin event before synchroniser filled");

endmodule : pirq_flag_bank

// file: tb/pirq_periph_model.sv
`timescale 1ns/1ps

// --------
// Event sources
// --------
module pirq_periph_model (
    // Clock
    input wire logic clk_sys,
    // Pulse sources
    output logic eewriteDone,
    output logic cryptoDone,
    output logic timerOneOvf,
    // Level sources
    output logic lowvoltCrossed,
    output logic cmpBOutput,
    output logic cmpAOutput,
    output logic oscFailed
);
    initial begin
        {eewriteDone, cryptoDone, timerOneOvf} = 3'h0;
        {lowvoltCrossed, cmpBOutput, cmpAOutput, oscFailed} = 4'h0;
    end

    // Levels held long enough for the synchroniser to agree
    task automatic fire(input int idx);
        @(posedge clk_sys);
        case (idx)
            7: eewriteDone <= 1'b1;
            6: lowvoltCrossed <= 1'b1;
            5: cryptoDone <= 1'b1;
            4: cmpBOutput <= ~cmpBOutput;
            3: cmpAOutput <= ~cmpAOutput;
            2: oscFailed <= 1'b1;
            default: timerOneOvf <= 1'b1;
        endcase
        @(posedge clk_sys);
        {eewriteDone, cryptoDone, timerOneOvf} <= 3'h0;
        repeat (3) @(posedge clk_sys);
        {lowvoltCrossed, oscFailed} <= 2'h0;
        @(posedge clk_sys);
    endtask : fire
endmodule : pirq_periph_model

// file: tb/tb.sv
`timescale 1ns/1ps
`include "pirq_params.svh"

module tb;
    // --------
    // Signals
    // --------
    logic clk_sys, rstn, psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr, err, coreIrq, busIrq;
    logic clkEn;
    logic eewriteDone, cryptoDone, timerOneOvf;
    logic lowvoltCrossed, cmpBOutput, cmpAOutput, oscFailed;
    int errorCnt, nTests;

    pirq_flag_bank u_pirq_flag_bank (
        .clk_sys(clk_sys), .rstn(rstn), .clkEn(clkEn),
        .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr),
        .eewriteDone(eewriteDone), .cryptoDone(cryptoDone),
        .timerOneOvf(timerOneOvf), .lowvoltCrossed(lowvoltCrossed),
        .cmpBOutput(cmpBOutput), .cmpAOutput(cmpAOutput),
        .oscFailed(oscFailed), .coreIrq(coreIrq), .busIrq(busIrq)
    );

    pirq_periph_model u_pirq_periph_model (
        .clk_sys(clk_sys), .eewriteDone(eewriteDone),
        .cryptoDone(cryptoDone), .timerOneOvf(timerOneOvf),
        .lowvoltCrossed(lowvoltCrossed), .cmpBOutput(cmpBOutput),
        .cmpAOutput(cmpAOutput), .oscFailed(oscFailed)
    );

    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    // --------
    // Helpers
    // --------
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        nTests++;
        if (g !== e) begin
            errorCnt++;
            $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
        end
    endtask : chk

    // Entered just after a rising edge; leaves one edge after release
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1 && n < 20) begin
            n++;
            @(posedge clk_sys);
        end
        if (pready !== 1'b1) begin
            errorCnt++;
            $display("[FAIL] pready expected 1 seen %b", pready);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask : apb

    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task rdc(input string nm, input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(nm, e, rd);
    endtask : rdc

    task conclude;
        $display("comparisons %0d mismatches %0d", nTests, errorCnt);
        if (errorCnt == 0 && nTests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : conclude

    // --------
    // Tests
    // --------
    task t_reset;
        rdc("enable", `PIRQ_OFF_ENABLE, 32'h0);
        rdc("request", `PIRQ_OFF_REQUEST, 32'h0);
        rdc("ctrl", `PIRQ_OFF_CTRL, 32'h0);
        rdc("status", `PIRQ_OFF_STATUS, 32'h0);
        chk("coreIrq", 32'h0, coreIrq);
        chk("busIrq", 32'h0, busIrq);
        $display("test reset done");
    endtask : t_reset

    task t_regs;
        wr(`PIRQ_OFF_ENABLE, 32'hFFFFFFFF);
        rdc("enable", `PIRQ_OFF_ENABLE, 32'hFD);
        chk("pslverr", 32'h0, err);
        wr(`PIRQ_OFF_REQUEST, 32'hFF);
        rdc("request", `PIRQ_OFF_REQUEST, 32'hFD);
        wr(`PIRQ_OFF_REQUEST, 32'h0);
        rdc("request", `PIRQ_OFF_REQUEST, 32'h0);
        wr(`PIRQ_OFF_ENABLE, 32'h0);
        $display("test registers done");
    endtask : t_regs

    task t_events;
        int src[7];
        src = '{7, 6, 5, 4, 3, 2, 0};
        foreach (src[i]) begin
            u_pirq_periph_model.fire(src[i]);
            repeat (6) @(posedge clk_sys);
            rdc("flag", `PIRQ_OFF_REQUEST, 32'h1 << src[i]);
            chk("coreIrq", 32'h0, coreIrq);
            repeat (5) @(posedge clk_sys);
            rdc("sticky", `PIRQ_OFF_REQUEST, 32'h1 << src[i]);
            wr(`PIRQ_OFF_REQUEST, 32'h0);
        end
        $display("test events done");
    endtask : t_events

    task t_gate;
        wr(`PIRQ_OFF_REQUEST, 32'h0);
        wr(`PIRQ_OFF_IRQEN, 32'h1);
        wr(`PIRQ_OFF_ENABLE, 32'h1);
        u_pirq_periph_model.fire(0);
        for (int c = 0; c < 4; c++) begin
            wr(`PIRQ_OFF_CTRL, 32'(c));
            repeat (2) @(posedge clk_sys);
            chk("coreIrq", 32'(c == 3), coreIrq);
        end
        repeat (2) @(posedge clk_sys);
        chk("busIrq", 32'h1, busIrq);
        rdc("ctrl", `PIRQ_OFF_CTRL, 32'h3);
        rdc("irqen", `PIRQ_OFF_IRQEN, 32'h1);
        wr(`PIRQ_OFF_ENABLE, 32'h0);
        repeat (2) @(posedge clk_sys);
        chk("coreIrq", 32'h0, coreIrq);
        rdc("status", `PIRQ_OFF_STATUS, 32'h1);
        wr(`PIRQ_OFF_CLEAR, 32'h1);
        repeat (2) @(posedge clk_sys);
        rdc("status", `PIRQ_OFF_STATUS, 32'h0);
        chk("busIrq", 32'h0, busIrq);
        rdc("clear", `PIRQ_OFF_CLEAR, 32'h0);
        apb(1'b0, 12'h020, 32'h0);
        chk("pslverr", 32'h1, err);
        chk("unmapped", 32'h0, rd);
        $display("test gating done");
    endtask : t_gate

    task t_freeze;
        wr(`PIRQ_OFF_REQUEST, 32'h0);
        clkEn <= 1'b0;
        u_pirq_periph_model.fire(7);
        clkEn <= 1'b1;
        rdc("frozen", `PIRQ_OFF_REQUEST, 32'h0);
        wr(`PIRQ_OFF_ENABLE, 32'h1);
        u_pirq_periph_model.fire(0);
        chk("coreIrq", 32'h1, coreIrq);
        chk("busIrq", 32'h1, busIrq);
        rstn <= 1'b0;
        repeat (2) @(posedge clk_sys);
        chk("coreIrq", 32'h0, coreIrq);
        rstn <= 1'b1;
        repeat (8) @(posedge clk_sys);
        chk("busIrq", 32'h0, busIrq);
        rdc("request", `PIRQ_OFF_REQUEST, 32'h0);
        rdc("enable", `PIRQ_OFF_ENABLE, 32'h0);
        rdc("ctrl", `PIRQ_OFF_CTRL, 32'h0);
        $display("test freeze and reset done");
    endtask : t_freeze

    initial begin
        {rstn, psel, penable, pwrite} = 4'h0;
        clkEn = 1'b1;
        paddr = 12'h000;
        pwdata = 32'h0;
        errorCnt = 0;
        nTests = 0;
        repeat (5) @(posedge clk_sys);
        rstn <= 1'b1;
        @(posedge clk_sys);
        t_reset;
        t_regs;
        t_events;
        t_gate;
        t_freeze;
        conclude;
    end

    initial begin
        repeat (3000) @(posedge clk_sys);
        errorCnt++;
        conclude;
    end
endmodule : tb
